// ==== rtl/afp_pkg.sv ====
// shared constants and carriers of the audio effects and power control block
package afp_pkg;

  // =====================================================
  // register map (word index on the control port)
  localparam logic [2:0] REG_AUDIO_PATH = 3'h0;
  localparam logic [2:0] REG_RECORD_VOL = 3'h1;
  localparam logic [2:0] REG_AUDIO_MISC = 3'h4;
  localparam logic [2:0] REG_POWER = 3'h5;
  localparam logic [2:0] REG_COEF_LEFT = 3'h2;
  localparam logic [2:0] REG_COEF_RIGHT = 3'h3;
  localparam logic [2:0] REG_BYPASS_VOL = 3'h6;
  localparam logic [2:0] REG_STATUS = 3'h7;

  // =====================================================
  // reset values
  localparam logic [15:0] PATH_RESET = 16'hc003;
  localparam logic [15:0] RECVOL_RESET = 16'h0000;
  localparam logic [15:0] MISC_RESET = 16'h0000;
  localparam logic [15:0] POWER_RESET = 16'h0000;
  localparam logic [15:0] BYPVOL_RESET = 16'h0000;

  // =====================================================
  // field positions
  localparam int HPF_LSB = 14;
  localparam int INSEL_LSB = 12;
  localparam int MIC_PREAMP_GAIN_LSB = 8;
  localparam int FS_LSB = 2;
  localparam int PWR_DEEMPHASIS_ENABLE_BIT = 0;
  localparam int PWR_EFFECT_BIT = 1;
  localparam int PWR_MICROPHONE_BIAS_OUTPUT_BIT = 6;
  localparam int PWR_ALL_BIT = 15;
  localparam int PWR_VCM_BIT = 14;
  localparam int PWR_BYPASS_BIT = 13;
  localparam int MISC_MONO_BIT = 2;

  // sample rate codes that allow de-emphasis
  localparam logic [3:0] FS_48K = 4'h0;
  localparam logic [3:0] FS_44K1 = 4'h1;
  localparam logic [3:0] FS_32K = 4'h2;

  // =====================================================
  // effects filter reset coefficients, index order n0 n1 n2 d1 d2
  localparam logic signed [15:0] COEF_N0 = 16'sh6be2;
  localparam logic signed [15:0] COEF_N1 = 16'sh9667;
  localparam logic signed [15:0] COEF_N2 = 16'sh675d;
  localparam logic signed [15:0] COEF_D1 = 16'sh7d82;
  localparam logic signed [15:0] COEF_D2 = 16'sh84ef;

  // de-emphasis coefficients, q15, 50 us pole and 15 us zero per rate
  localparam logic signed [15:0] DE_B0_48 = 16'sh5d69;
  localparam logic signed [15:0] DE_B1_48 = 16'she4c6;
  localparam logic signed [15:0] DE_A1_48 = 16'sh3f30;
  localparam logic signed [15:0] DE_B0_44 = 16'sh5c20;
  localparam logic signed [15:0] DE_B1_44 = 16'she558;
  localparam logic signed [15:0] DE_A1_44 = 16'sh3e78;
  localparam logic signed [15:0] DE_B0_32 = 16'sh5645;
  localparam logic signed [15:0] DE_B1_32 = 16'she839;
  localparam logic signed [15:0] DE_A1_32 = 16'sh3404;

  // =====================================================
  // timing
  localparam int CLK_MHZ = 200;
  localparam int STEP_US = 20;
  localparam int STEP_CYCLES = STEP_US * CLK_MHZ;
  localparam logic [5:0] VOL_MUTE = 6'h00;

  // =====================================================
  // carriers
  typedef struct packed {
    logic signed [19:0] left;
    logic signed [19:0] right;
  } afp_frame_type;

  typedef struct packed {
    logic [1:0] hpf_sel;
    logic [1:0] in_sel;
    logic [1:0] mic_gain;
    logic [6:0] rec_vol;
    logic rec_mute;
    logic mono_sel;
    logic microphone_bias_output_off;
  } afp_analog_type;

  typedef enum logic [1:0] {
    BYP_OFF = 2'b00,
    BYP_RAMP_UP = 2'b01,
    BYP_ON = 2'b10,
    BYP_RAMP_DOWN = 2'b11
  } afp_byp_state_type;

endpackage : afp_pkg

// ==== rtl/afp_filter_top.sv ====
// playback effects filters, analog settings and power sequencing of the audio codec
`timescale 1ns/10ps
// How it works
// - de-emphasis filter acts only while deemphasis_enable is set
// - de-emphasis only for 32, 44.1 and 48 kHz sample rates
// - de-emphasis has a 50 us pole and a 15 us zero
// - per-channel fourth-order effects filter, two cascaded biquads over 32768
// - effects filter bypassed unless enabled; host loads coefficients, toggles enable
// - reset coefficients are 27618, -27033, 26461 and 32130, -31505
// - coefficients are 16-bit two's complement integers
// - record modulator oversamples by 128 at every rate
// - record high-pass corner selectable among three fractions of Fs
// - decimation ripple and stopband are analog-side figures, not passed out as settings
// - record group delay is 28.7 sample periods
// - record volume +20 to -40 dB in half-dB steps plus mute
// - adc_input_select picks mic, left line, right line or average
// - mic_preamp_gain gives 0, 6 or 12 dB
// - bypass volume +12.0 to -35.5 dB in half-dB steps; six-bit code here tops out at 63, -4.5 dB
// - applied bypass volume steps once per 20 us toward target
// - bypass power-up starts at mute and steps up
// - bypass power-down steps to mute before removing power
// - mono_source_select picks line mix or record converter input
// - mic_bias_powerdown disables the microphone bias output
// - power register holds power-down bits; bit 15 forces all of them set, bit 13 only once the bypass ramp reaches mute
// - bits 15 and 14 power down all, or all but common mode reference
// - adc_highpass_select codes 00 off, 01, 10, 11; resets to 11
// - adc_input_select resets to microphone
module afp_filter_top #(
  parameter int STEP_COUNT = afp_pkg::STEP_CYCLES,
  parameter int DATA_W = 20
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic reg_wr,
  input wire logic [2:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  input wire logic in_valid,
  output logic in_ready,
  input wire afp_pkg::afp_frame_type in_frame,
  output logic out_valid,
  input wire logic out_ready,
  output afp_pkg::afp_frame_type out_frame,
  output afp_pkg::afp_analog_type analog_ctrl,
  output logic [5:0] bypass_vol_applied,
  output logic [15:0] power_down,
  output logic common_mode_reference_off
);

  // =====================================================
  // control registers
  logic [15:0] path_reg;
  logic [15:0] recvol_reg;
  logic [15:0] misc_reg;
  logic [15:0] power_reg;
  logic [15:0] bypvol_reg;
  logic signed [15:0] coef_reg [0:1][0:4];
  logic [2:0] coef_ptr_reg [0:1];

  // host writes to the mapped registers
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      path_reg <= afp_pkg::PATH_RESET;
      recvol_reg <= afp_pkg::RECVOL_RESET;
      misc_reg <= afp_pkg::MISC_RESET;
      power_reg <= afp_pkg::POWER_RESET;
      bypvol_reg <= afp_pkg::BYPVOL_RESET;
    end
    else if (reg_wr)
    begin
      unique case (reg_addr)
        afp_pkg::REG_AUDIO_PATH: path_reg <= reg_wdata;
        afp_pkg::REG_RECORD_VOL: recvol_reg <= reg_wdata;
        afp_pkg::REG_AUDIO_MISC: misc_reg <= reg_wdata;
        afp_pkg::REG_POWER: power_reg <= reg_wdata;
        afp_pkg::REG_BYPASS_VOL: bypvol_reg <= reg_wdata;
        default: ;
      endcase
    end
  end

  // coefficients kept as 16-bit signed words, written in turn n0 n1 n2 d1 d2
  generate
    for (genvar ch = 0; ch < 2; ch++)
    begin : g_coef
      always_ff @(posedge core_clk or negedge arst_n)
      begin
        if (!arst_n)
        begin
          coef_reg[ch][0] <= afp_pkg::COEF_N0;
          coef_reg[ch][1] <= afp_pkg::COEF_N1;
          coef_reg[ch][2] <= afp_pkg::COEF_N2;
          coef_reg[ch][3] <= afp_pkg::COEF_D1;
          coef_reg[ch][4] <= afp_pkg::COEF_D2;
          coef_ptr_reg[ch] <= 3'h0;
        end
        else if (reg_wr && reg_addr ==
                 (ch == 0 ? afp_pkg::REG_COEF_LEFT : afp_pkg::REG_COEF_RIGHT))
        begin
          coef_reg[ch][coef_ptr_reg[ch]] <= reg_wdata;
          coef_ptr_reg[ch] <= (coef_ptr_reg[ch] == 3'h4) ? 3'h0 : coef_ptr_reg[ch] + 3'h1;
        end
      end
    end
  endgenerate

  // =====================================================
  // bypass volume soft stepping
  afp_pkg::afp_byp_state_type byp_state_reg;
  logic [5:0] byp_vol_reg;
  logic [$clog2(STEP_COUNT+1)-1:0] step_cnt_reg;
  logic step_tick;
  logic byp_pd_req;
  logic [5:0] byp_target;

  assign byp_pd_req = power_reg[afp_pkg::PWR_BYPASS_BIT] | power_reg[afp_pkg::PWR_ALL_BIT];
  // six-bit code, 0 mute, 1 = -35.5 dB up to 96 steps; only bits 5:0 kept here, codes above 63 wrap
  assign byp_target = bypvol_reg[5:0];

  // one step tick each 20 us
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      step_cnt_reg <= '0;
    else if (step_tick)
      step_cnt_reg <= '0;
    else
      step_cnt_reg <= step_cnt_reg + 1'b1;
  end
  assign step_tick = (step_cnt_reg == ($clog2(STEP_COUNT+1))'(STEP_COUNT - 1));

  // ramp sequencer; power stays applied until the ramp reaches mute
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      byp_state_reg <= afp_pkg::BYP_OFF;
      byp_vol_reg <= afp_pkg::VOL_MUTE;
    end
    else
    begin
      unique case (byp_state_reg)
        afp_pkg::BYP_OFF:
        begin
          byp_vol_reg <= afp_pkg::VOL_MUTE;
          if (!byp_pd_req)
            byp_state_reg <= afp_pkg::BYP_RAMP_UP;
        end
        afp_pkg::BYP_RAMP_UP, afp_pkg::BYP_ON:
        begin
          if (byp_pd_req)
            byp_state_reg <= afp_pkg::BYP_RAMP_DOWN;
          else if (step_tick && byp_vol_reg < byp_target)
            byp_vol_reg <= byp_vol_reg + 6'h01;
          else if (step_tick && byp_vol_reg > byp_target)
            byp_vol_reg <= byp_vol_reg - 6'h01;
          else if (byp_vol_reg == byp_target)
            byp_state_reg <= afp_pkg::BYP_ON;
        end
        afp_pkg::BYP_RAMP_DOWN:
        begin
          if (byp_vol_reg == afp_pkg::VOL_MUTE)
            byp_state_reg <= afp_pkg::BYP_OFF;
          else if (step_tick)
            byp_vol_reg <= byp_vol_reg - 6'h01;
        end
      endcase
    end
  end

  // =====================================================
  // input buffer, two entries
  afp_pkg::afp_frame_type buf_reg [0:1];
  logic [1:0] buf_cnt_reg;
  logic buf_rd_reg;
  logic buf_wr_reg;
  logic take_in;
  logic take_buf;
  logic pipe_busy_reg;

  assign in_ready = (buf_cnt_reg != 2'h2);
  assign take_in = in_valid & in_ready;
  assign take_buf = (buf_cnt_reg != 2'h0) & ~pipe_busy_reg;

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      buf_cnt_reg <= 2'h0;
      buf_rd_reg <= 1'b0;
      buf_wr_reg <= 1'b0;
    end
    else
    begin
      if (take_in)
        buf_wr_reg <= ~buf_wr_reg;
      if (take_buf)
        buf_rd_reg <= ~buf_rd_reg;
      buf_cnt_reg <= buf_cnt_reg + {1'b0, take_in} - {1'b0, take_buf};
    end
  end

  // buffer storage needs no reset
  always_ff @(posedge core_clk)
  begin
    if (take_in)
      buf_reg[buf_wr_reg] <= in_frame;
  end

  // =====================================================
  // processing: stage 0 de-emphasis, stages 1 and 2 biquads
  logic deemphasis_enable_ok;
  logic signed [15:0] de_b0;
  logic signed [15:0] de_b1;
  logic signed [15:0] de_a1;
  logic signed [DATA_W-1:0] x_reg [0:1];
  logic signed [DATA_W-1:0] de_x1_reg [0:1];
  logic signed [DATA_W-1:0] de_y1_reg [0:1];
  logic signed [DATA_W-1:0] bq_x1_reg [0:1][0:1];
  logic signed [DATA_W-1:0] bq_x2_reg [0:1][0:1];
  logic signed [DATA_W-1:0] bq_y1_reg [0:1][0:1];
  logic signed [DATA_W-1:0] bq_y2_reg [0:1][0:1];
  logic [1:0] phase_reg;

  always_comb
  begin
    deemphasis_enable_ok = 1'b1;
    de_b0 = afp_pkg::DE_B0_48;
    de_b1 = afp_pkg::DE_B1_48;
    de_a1 = afp_pkg::DE_A1_48;
    unique case (path_reg[afp_pkg::FS_LSB +: 4])
      afp_pkg::FS_48K: ;
      afp_pkg::FS_44K1:
      begin
        de_b0 = afp_pkg::DE_B0_44;
        de_b1 = afp_pkg::DE_B1_44;
        de_a1 = afp_pkg::DE_A1_44;
      end
      afp_pkg::FS_32K:
      begin
        de_b0 = afp_pkg::DE_B0_32;
        de_b1 = afp_pkg::DE_B1_32;
        de_a1 = afp_pkg::DE_A1_32;
      end
      default: deemphasis_enable_ok = 1'b0;
    endcase
  end

  // saturating q15 scale of a 48-bit product sum
  function automatic logic signed [DATA_W-1:0] afp_sat(input logic signed [47:0] acc);
    logic signed [47:0] sh;
    sh = acc >>> 15;
    if (sh > 48'sd524287)
      afp_sat = 20'sh7ffff;
    else if (sh < -48'sd524288)
      afp_sat = 20'sh80000;
    else
      afp_sat = sh[DATA_W-1:0];
  endfunction : afp_sat

  // first-order shelf y = b0 x + b1 x1 + a1 y1
  function automatic logic signed [DATA_W-1:0] afp_deemphasis_enable(
    input logic signed [DATA_W-1:0] x, input logic signed [DATA_W-1:0] x1,
    input logic signed [DATA_W-1:0] y1, input logic signed [15:0] b0,
    input logic signed [15:0] b1, input logic signed [15:0] a1);
    afp_deemphasis_enable = afp_sat(48'(x * b0) + 48'(x1 * b1) + 48'(y1 * a1));
  endfunction : afp_deemphasis_enable

  // a x + 2b x1 + c x2 + 2d y1 + e y2, all over 32768
  function automatic logic signed [DATA_W-1:0] afp_biquad(
    input logic signed [DATA_W-1:0] x, input logic signed [DATA_W-1:0] x1,
    input logic signed [DATA_W-1:0] x2, input logic signed [DATA_W-1:0] y1,
    input logic signed [DATA_W-1:0] y2, input logic signed [15:0] a,
    input logic signed [15:0] b, input logic signed [15:0] c,
    input logic signed [15:0] d, input logic signed [15:0] e);
    afp_biquad = afp_sat(48'(x * a) + 48'(x1 * b) * 2 + 48'(x2 * c)
                         + 48'(y1 * d) * 2 + 48'(y2 * e));
  endfunction : afp_biquad

  // one frame walks through four phases, 0 to 3; the result waits in out_frame
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      phase_reg <= 2'h0;
      pipe_busy_reg <= 1'b0;
      out_valid <= 1'b0;
      out_frame <= '0;
      for (int c = 0; c < 2; c++)
      begin
        x_reg[c] <= '0;
        de_x1_reg[c] <= '0;
        de_y1_reg[c] <= '0;
        for (int s = 0; s < 2; s++)
        begin
          bq_x1_reg[c][s] <= '0;
          bq_x2_reg[c][s] <= '0;
          bq_y1_reg[c][s] <= '0;
          bq_y2_reg[c][s] <= '0;
        end
      end
    end
    else
    begin
      if (out_valid && out_ready)
        out_valid <= 1'b0;
      if (take_buf)
      begin
        x_reg[0] <= buf_reg[buf_rd_reg].left;
        x_reg[1] <= buf_reg[buf_rd_reg].right;
        pipe_busy_reg <= 1'b1;
        phase_reg <= 2'h0;
      end
      else if (pipe_busy_reg)
      begin
        for (int c = 0; c < 2; c++)
        begin
          unique case (phase_reg)
            2'h0:
            begin
              if (power_reg[afp_pkg::PWR_DEEMPHASIS_ENABLE_BIT] && deemphasis_enable_ok)
              begin
                x_reg[c] <= afp_deemphasis_enable(x_reg[c], de_x1_reg[c], de_y1_reg[c], de_b0, de_b1, de_a1);
                de_y1_reg[c] <= afp_deemphasis_enable(x_reg[c], de_x1_reg[c], de_y1_reg[c],
                  de_b0, de_b1, de_a1);
              end
              de_x1_reg[c] <= x_reg[c];
            end
            2'h1, 2'h2:
            begin
              if (power_reg[afp_pkg::PWR_EFFECT_BIT])
              begin
                x_reg[c] <= afp_biquad(x_reg[c], bq_x1_reg[c][phase_reg[1]],
                  bq_x2_reg[c][phase_reg[1]], bq_y1_reg[c][phase_reg[1]],
                  bq_y2_reg[c][phase_reg[1]], coef_reg[c][0], coef_reg[c][1],
                  coef_reg[c][2], coef_reg[c][3], coef_reg[c][4]);
                bq_y1_reg[c][phase_reg[1]] <= afp_biquad(x_reg[c], bq_x1_reg[c][phase_reg[1]],
                  bq_x2_reg[c][phase_reg[1]], bq_y1_reg[c][phase_reg[1]],
                  bq_y2_reg[c][phase_reg[1]], coef_reg[c][0], coef_reg[c][1],
                  coef_reg[c][2], coef_reg[c][3], coef_reg[c][4]);
                bq_y2_reg[c][phase_reg[1]] <= bq_y1_reg[c][phase_reg[1]];
                bq_x2_reg[c][phase_reg[1]] <= bq_x1_reg[c][phase_reg[1]];
                bq_x1_reg[c][phase_reg[1]] <= x_reg[c];
              end
            end
            default: ;
          endcase
        end
        if (phase_reg == 2'h3 && !out_valid)
        begin
          out_frame.left <= x_reg[0];
          out_frame.right <= x_reg[1];
          out_valid <= 1'b1;
          pipe_busy_reg <= 1'b0;
        end
        else if (phase_reg != 2'h3)
          phase_reg <= phase_reg + 2'h1;
      end
    end
  end

  // =====================================================
  // analog settings and power outputs, registered
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      analog_ctrl <= '0;
      bypass_vol_applied <= afp_pkg::VOL_MUTE;
      power_down <= 16'hffff;
      common_mode_reference_off <= 1'b0;
    end
    else
    begin
      analog_ctrl.hpf_sel <= path_reg[afp_pkg::HPF_LSB +: 2];
      analog_ctrl.in_sel <= path_reg[afp_pkg::INSEL_LSB +: 2];
      analog_ctrl.mic_gain <= path_reg[afp_pkg::MIC_PREAMP_GAIN_LSB +: 2];
      analog_ctrl.rec_vol <= recvol_reg[6:0];
      analog_ctrl.rec_mute <= recvol_reg[15];
      analog_ctrl.mono_sel <= misc_reg[afp_pkg::MISC_MONO_BIT];
      analog_ctrl.microphone_bias_output_off <= power_reg[afp_pkg::PWR_MICROPHONE_BIAS_OUTPUT_BIT]
                                 | power_reg[afp_pkg::PWR_ALL_BIT];
      bypass_vol_applied <= byp_vol_reg;
      power_down <= power_reg[afp_pkg::PWR_ALL_BIT] ? 16'hffff : power_reg;
      power_down[afp_pkg::PWR_BYPASS_BIT] <= (byp_state_reg == afp_pkg::BYP_OFF);
      common_mode_reference_off <= power_reg[afp_pkg::PWR_ALL_BIT]
                                   & power_reg[afp_pkg::PWR_VCM_BIT];
    end
  end

  // readback; status word shows applied volume and ramp state
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      reg_rdata <= '0;
    else
    begin
      unique case (reg_addr)
        afp_pkg::REG_AUDIO_PATH: reg_rdata <= path_reg;
        afp_pkg::REG_RECORD_VOL: reg_rdata <= recvol_reg;
        afp_pkg::REG_AUDIO_MISC: reg_rdata <= misc_reg;
        afp_pkg::REG_POWER: reg_rdata <= power_reg;
        afp_pkg::REG_BYPASS_VOL: reg_rdata <= bypvol_reg;
        afp_pkg::REG_STATUS: reg_rdata <= {8'h00, byp_state_reg, byp_vol_reg};
        default: reg_rdata <= {13'h0000, coef_ptr_reg[reg_addr[0]]};
      endcase
    end
  end

  // oversampling, passband, group delay live in the analog and
  // decimation hardware outside this block; only the corner select passes out
endmodule : afp_filter_top

// ==== verification/afp_checker_assertions.sv ====
// port checker of the audio filter and power control block
`timescale 1ns/10ps
module afp_checker #(
  parameter int STEP_COUNT = 4
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic reg_wr,
  input wire logic [2:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic out_valid,
  input wire logic out_ready,
  input wire afp_pkg::afp_frame_type out_frame,
  input wire afp_pkg::afp_analog_type analog_ctrl,
  input wire logic [5:0] bypass_vol_applied,
  input wire logic [15:0] power_down,
  input wire logic common_mode_reference_off
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  logic [5:0] vol_last_reg;
  logic [15:0] gap_reg;
  // =====================================================
  // cycles since the applied volume last moved, saturating
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      vol_last_reg <= 6'h00;
      gap_reg <= 16'hffff;
    end
    else
    begin
      vol_last_reg <= bypass_vol_applied;
      if (bypass_vol_applied != vol_last_reg)
        gap_reg <= 16'h0000;
      else if (gap_reg != 16'hffff)
        gap_reg <= gap_reg + 16'h0001;
    end
  end
  // =====================================================
  // assertions
  a_vol_single_step: assert property ((bypass_vol_applied != vol_last_reg) |->
    (bypass_vol_applied == vol_last_reg + 6'h01 || bypass_vol_applied == vol_last_reg - 6'h01))
    else $error("bypass volume moved more than one step");
  a_vol_step_gap: assert property ((bypass_vol_applied != vol_last_reg) |->
    int'(gap_reg) >= STEP_COUNT - 1) else $error("bypass volume stepped too early");
  a_off_at_mute: assert property ($rose(power_down[13]) |-> bypass_vol_applied == 6'h00)
    else $error("bypass powered down before mute");
  a_on_from_mute: assert property ($fell(power_down[13]) |-> bypass_vol_applied == 6'h00)
    else $error("bypass powered up above mute");
  a_out_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_frame))
    else $error("output frame dropped while stalled");
  a_cmr_off: assert property (reg_wr && reg_addr == afp_pkg::REG_POWER |-> ##2
    common_mode_reference_off == ($past(reg_wdata[15], 2) && $past(reg_wdata[14], 2)))
    else $error("common mode reference state wrong");
  a_microphone_bias_output_off: assert property (reg_wr && reg_addr == afp_pkg::REG_POWER |-> ##2
    analog_ctrl.microphone_bias_output_off == ($past(reg_wdata[6], 2) || $past(reg_wdata[15], 2)))
    else $error("mic bias state wrong");
  a_mono_select: assert property (reg_wr && reg_addr == afp_pkg::REG_AUDIO_MISC |-> ##2
    analog_ctrl.mono_sel == $past(reg_wdata[2], 2)) else $error("mono source wrong");
  a_hpf_field: assert property (reg_wr && reg_addr == afp_pkg::REG_AUDIO_PATH |-> ##2
    analog_ctrl.hpf_sel == $past(reg_wdata[15:14], 2)) else $error("high-pass select wrong");
  a_insel_field: assert property (reg_wr && reg_addr == afp_pkg::REG_AUDIO_PATH |-> ##2
    analog_ctrl.in_sel == $past(reg_wdata[13:12], 2)) else $error("input select wrong");
endmodule : afp_checker
bind afp_filter_top afp_checker #(.STEP_COUNT(STEP_COUNT)) chk (.core_clk, .arst_n, .reg_wr,
  .reg_addr, .reg_wdata, .out_valid, .out_ready, .out_frame, .analog_ctrl,
  .bypass_vol_applied, .power_down, .common_mode_reference_off);

// ==== verification/afp_stream_sink.sv ====
// far-side sink model that collects output frames and can stall
`timescale 1ns/10ps
module afp_stream_sink (
  input wire logic core_clk,
  input wire logic stall,
  input wire logic out_valid,
  input wire afp_pkg::afp_frame_type out_frame,
  output logic out_ready
);
  afp_pkg::afp_frame_type got[$];
  initial out_ready = 1'b0;
  // =====================================================
  // ready moves off the sampling edge so takes never race
  always @(negedge core_clk) out_ready <= !stall;
  always @(posedge core_clk)
  begin
    if (out_valid && out_ready)
      got.push_back(out_frame);
  end
endmodule : afp_stream_sink

// ==== verification/test_afp_filter_top.sv ====
// self-checking bench of the audio filter and power control block
`timescale 1ns/10ps
module test_afp_filter_top;
  localparam int STEPS = 4;
  logic core_clk, arst_n, reg_wr, in_valid, in_ready, out_valid, out_ready, stall;
  logic [2:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, power_down;
  logic [5:0] bypass_vol_applied;
  logic common_mode_reference_off;
  afp_pkg::afp_frame_type in_frame, out_frame;
  afp_pkg::afp_analog_type analog_ctrl;
  int n_errors = 0;
  int num_checks = 0;
  afp_filter_top #(.STEP_COUNT(STEPS)) DUT (.core_clk, .arst_n, .reg_wr, .reg_addr, .reg_wdata,
    .reg_rdata, .in_valid, .in_ready, .in_frame, .out_valid, .out_ready, .out_frame,
    .analog_ctrl, .bypass_vol_applied, .power_down, .common_mode_reference_off);
  afp_stream_sink sink (.core_clk, .stall, .out_valid, .out_frame, .out_ready);
  // =====================================================
  // shared tasks
  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // write then let the two-cycle output latency pass
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(negedge core_clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge core_clk);
    reg_wr = 1'b0;
    repeat (2) @(negedge core_clk);
  endtask : wr
  task automatic rdchk(input logic [2:0] a, input logic [15:0] exp);
    @(negedge core_clk);
    reg_addr = a;
    @(negedge core_clk);
    check(reg_rdata, exp);
  endtask : rdchk
  // bounded wait for the applied volume
  task automatic wait_vol(input logic [5:0] exp);
    for (int i = 0; i < 100 && bypass_vol_applied !== exp; i++)
      @(negedge core_clk);
    check(bypass_vol_applied, exp);
  endtask : wait_vol
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
    begin
      $display("Result: passed");
    end
    else
    begin
      $display("Result: failed");
    end
    $finish;
  endtask : close_out
  // =====================================================
  // scenarios
  task automatic t_reset;
    rdchk(afp_pkg::REG_AUDIO_PATH, afp_pkg::PATH_RESET);
    check(analog_ctrl.hpf_sel, 2'b11);
    check(analog_ctrl.in_sel, 2'b00);
    rdchk(afp_pkg::REG_POWER, 16'h0000);
    $display("test reset done");
  endtask : t_reset
  task automatic t_fields;
    logic [1:0] c;
    for (int i = 0; i < 4; i++)
    begin
      c = 2'(i);
      wr(afp_pkg::REG_AUDIO_PATH, {c, c, 2'b00, c, 8'h03});
      check(analog_ctrl.hpf_sel, c);
      check(analog_ctrl.in_sel, c);
      check(analog_ctrl.mic_gain, c);
      rdchk(afp_pkg::REG_AUDIO_PATH, {c, c, 2'b00, c, 8'h03});
    end
    $display("test fields done");
  endtask : t_fields
  task automatic t_power;
    wr(afp_pkg::REG_POWER, 16'hc040);
    check(common_mode_reference_off, 1'b1);
    check(analog_ctrl.microphone_bias_output_off, 1'b1);
    check(power_down[15:14], 2'b11);
    wr(afp_pkg::REG_POWER, 16'h8000);
    check(common_mode_reference_off, 1'b0);
    check(analog_ctrl.microphone_bias_output_off, 1'b1);
    wr(afp_pkg::REG_AUDIO_MISC, 16'h0004);
    check(analog_ctrl.mono_sel, 1'b1);
    wr(afp_pkg::REG_AUDIO_MISC, 16'h0000);
    check(analog_ctrl.mono_sel, 1'b0);
    wr(afp_pkg::REG_RECORD_VOL, 16'h8055);
    check({analog_ctrl.rec_mute, analog_ctrl.rec_vol}, 8'hd5);
    wr(afp_pkg::REG_POWER, 16'h0550);
    check({power_down[15:14], power_down[12:0]}, 15'h0550);
    wr(afp_pkg::REG_POWER, 16'h0000);
    $display("test power done");
  endtask : t_power
  task automatic t_ramp;
    wr(afp_pkg::REG_BYPASS_VOL, 16'h0005);
    wait_vol(6'h05);
    wr(afp_pkg::REG_POWER, 16'h2000);
    check(power_down[13], 1'b0);
    wait_vol(6'h00);
    for (int i = 0; i < 20 && power_down[13] !== 1'b1; i++)
      @(negedge core_clk);
    check(power_down[13], 1'b1);
    wr(afp_pkg::REG_POWER, 16'h0000);
    check(bypass_vol_applied < 6'h02, 1'b1);
    wait_vol(6'h05);
    $display("test ramp done");
  endtask : t_ramp
  // fill until refused while the sink stalls, then drain and compare
  task automatic t_stream(input logic [19:0] base);
    afp_pkg::afp_frame_type sent[$];
    logic ok;
    sink.got.delete();
    stall = 1'b1;
    ok = 1'b1;
    for (int k = 0; k < 10 && ok; k++)
    begin
      @(negedge core_clk);
      in_valid = 1'b1;
      in_frame = {base + 20'(k), 20'hf0000 - 20'(k)};
      ok = in_ready;
      if (ok)
        sent.push_back(in_frame);
      @(posedge core_clk);
    end
    @(negedge core_clk);
    in_valid = 1'b0;
    check(ok, 1'b0);
    check(sent.size() >= 2, 1'b1);
    stall = 1'b0;
    for (int i = 0; i < 200 && sink.got.size() < sent.size(); i++)
      @(negedge core_clk);
    check(sink.got.size(), sent.size());
    foreach (sent[i])
      check(sink.got[i], sent[i]);
    check(in_ready, 1'b1);
    $display("test stream done");
  endtask : t_stream
  // one frame through the idle pipe, judged at the sink
  task automatic send1(input logic [39:0] f, input logic [39:0] exp);
    sink.got.delete();
    @(negedge core_clk);
    in_valid = 1'b1;
    in_frame = f;
    @(negedge core_clk);
    in_valid = 1'b0;
    for (int i = 0; i < 50 && sink.got.size() == 0; i++)
      @(negedge core_clk);
    check(sink.got.size(), 1);
    check(sink.got[0], exp);
  endtask : send1
  task automatic t_filters;
    // impulse responses; a zero frame with both filters off first clears only the de-emphasis input history
    wr(afp_pkg::REG_POWER, 16'h0000);
    wr(afp_pkg::REG_AUDIO_PATH, afp_pkg::PATH_RESET);
    send1('0, '0);
    wr(afp_pkg::REG_POWER, 16'h0001);
    send1({20'h08000, 20'h00000}, {20'(afp_pkg::DE_B0_48), 20'h00000});
    wr(afp_pkg::REG_POWER, 16'h0002);
    // two sections of n0 each: 27618 * 27618 / 32768
    send1({20'h08000, 20'h00000}, {20'h05aed, 20'h00000});
    $display("test filters done");
  endtask : t_filters
  // =====================================================
  // clock, watchdog and main sequence
  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  initial
  begin
    #(20000 * 5);
    n_errors++;
    close_out();
  end
  initial
  begin
    arst_n = 1'b0;
    reg_wr = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 16'h0000;
    in_valid = 1'b0;
    in_frame = '0;
    stall = 1'b0;
    repeat (10) @(negedge core_clk);
    arst_n = 1'b1;
    t_reset();
    t_fields();
    t_power();
    t_ramp();
    // both filters off pass frames untouched
    t_stream(20'h12345);
    wr(afp_pkg::REG_AUDIO_PATH, 16'hc00f);
    wr(afp_pkg::REG_POWER, 16'h0001);
    // de-emphasis on at an unsupported rate
    t_stream(20'h23456);
    t_filters();
    close_out();
  end
endmodule : test_afp_filter_top
